// [keypad_irq_defines.svh]
// Constants for the keypad wake interrupt unit
//
// Contract
// [R01] Four pins at most, each enabled alone
// [R02] Only enabled pins take part in detection
// [R03] Per pin falling, rising, low or high sensing
// [R04] One request, gated by the software enable
// [R05] Keeps working in wait and wakes processor
// [R06] Stop3 detects pins without clock, wakes processor; the code registers o_wake on i_sys_clk
// [R07] Deeper stop modes disable all detection
// [R08] Deeper stop wake leaves everything at reset
// [R09] Background debug behaves exactly like run
// [R10] Polarity select turns pull-up into pull-down
// [R11] Edge is inactive sample then active sample
// [R12] After an edge, wait for all inactive
// [R13] Event sets flag; acknowledge one clears it
// [R14] Level mode: acknowledge fails while input active
// [R15] Two-stage synchroniser ahead of detection
// [R16] Request is flag AND request enable
`ifndef KEYPAD_IRQ_DEFINES_SVH
`define KEYPAD_IRQ_DEFINES_SVH

// ========================================
// Sizes and reset values
`define KPI_NUM_PINS 4
`define KPI_SYNC_STAGES 2
`define KPI_RST_FLAG 1'b0
`define KPI_RST_IRQ_EN 1'b0
`define KPI_RST_MODE 1'b0
`define KPI_RST_PIN_EN 4'h0
`define KPI_RST_POL 4'h0

`endif

// [keypad_irq_pkg.sv]
// Types shared by the keypad wake interrupt unit
package keypad_irq_pkg;

	// Power mode of the surrounding part
	typedef enum logic [3:0] {
		PM_RUN = 4'b0001,
		PM_WAIT = 4'b0010,
		PM_STOP3 = 4'b0100,
		PM_DEEP = 4'b1000
	} power_mode_e;

endpackage : keypad_irq_pkg

// [keypad_pin_sync.sv]
// Two-stage synchroniser bank for the key input pins
`timescale 1ns/10ps

module keypad_pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// ========================================
	// Per-bit chain
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			// First stage only feeds the second, never any logic
			logic meta;
			always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					meta <= 1'b0;
					o_sync[g] <= 1'b0;
				end else begin
					meta <= i_async[g]; // R15
					o_sync[g] <= meta;
				end
			end
		end
	endgenerate

endmodule : keypad_pin_sync

// [keypad_irq_unit.sv]
// Keypad wake interrupt unit: pin detection, event flag, request and wake
`timescale 1ns/10ps
`include "keypad_irq_defines.svh"

module keypad_irq_unit #(
	parameter int NUM_PINS = `KPI_NUM_PINS
) (
	input wire logic i_sys_clk,
	input wire logic i_arst_n,
	// Raw key input pins
	input wire logic [NUM_PINS-1:0] i_key_input_pin_n,
	// Control bits
	input wire logic [NUM_PINS-1:0] i_pin_irq_enable_n,
	input wire logic [NUM_PINS-1:0] i_pin_polarity_select_n,
	input wire logic i_edge_level_mode,
	input wire logic i_irq_request_enable,
	input wire logic i_flag_acknowledge,
	input wire logic [NUM_PINS-1:0] i_pull_enable,
	input wire logic [3:0] i_power_mode,
	input wire logic i_ctrl_write,
	// Status and outputs
	output logic o_event_flag,
	output logic o_irq_request,
	output logic o_wake,
	output logic [NUM_PINS-1:0] o_pull_down_sel,
	output logic [NUM_PINS-1:0] o_pull_up_sel,
	output logic [NUM_PINS-1:0] o_pin_irq_enable_n,
	output logic [NUM_PINS-1:0] o_pin_polarity_select_n,
	output logic o_edge_level_mode,
	output logic o_irq_request_enable
);

	// ========================================
	// Mode decode
	logic deep_stop; // Deeper stop: unit powered down
	logic stop3; // Clock assumed gated, detection asynchronous
	assign deep_stop = i_power_mode == 4'(keypad_irq_pkg::PM_DEEP);
	assign stop3 = i_power_mode == 4'(keypad_irq_pkg::PM_STOP3);

	// ========================================
	// Control state; written when i_ctrl_write pulses
	// Deep stop forces reset values, so wake-up finds a clean unit
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pin_irq_enable_n <= `KPI_RST_PIN_EN;
			o_pin_polarity_select_n <= `KPI_RST_POL;
			o_edge_level_mode <= `KPI_RST_MODE;
			o_irq_request_enable <= `KPI_RST_IRQ_EN;
		end else if (deep_stop) begin
			o_pin_irq_enable_n <= `KPI_RST_PIN_EN; // R08
			o_pin_polarity_select_n <= `KPI_RST_POL; // R08
			o_edge_level_mode <= `KPI_RST_MODE;
			o_irq_request_enable <= `KPI_RST_IRQ_EN;
		end else if (i_ctrl_write) begin
			o_pin_irq_enable_n <= i_pin_irq_enable_n; // R01
			o_pin_polarity_select_n <= i_pin_polarity_select_n;
			o_edge_level_mode <= i_edge_level_mode;
			o_irq_request_enable <= i_irq_request_enable;
		end
	end

	// ========================================
	// Synchronised pins
	logic [NUM_PINS-1:0] pin_sync;
	keypad_pin_sync #(.WIDTH(NUM_PINS)) u_sync (
		.i_sys_clk(i_sys_clk),
		.i_arst_n(i_arst_n),
		.i_async(i_key_input_pin_n),
		.o_sync(pin_sync)
	);

	// ========================================
	// Active-level view: polarity 1 means high/rising is active
	logic [NUM_PINS-1:0] active_now; // Enabled pins at active level
	logic [NUM_PINS-1:0] active_prev; // Previous cycle's active_now, with disabled pins forced active
	logic any_active;
	logic any_edge;
	logic armed; // Cleared after an edge until all go inactive
	// Active when the pin level equals its polarity bit
	assign active_now = ~(pin_sync ^ o_pin_polarity_select_n)
		& o_pin_irq_enable_n; // R02 R03
	assign any_active = |active_now;
	// Inactive in one cycle, active in the next, while armed
	assign any_edge = armed && |(active_now & ~active_prev); // R11

	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			active_prev <= '1;
		end else begin
			// A pin freshly enabled while active counts as already active
			active_prev <= active_now | ~o_pin_irq_enable_n;
		end
	end

	// Rearm only when every enabled input has gone inactive
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			armed <= 1'b0;
		end else if (deep_stop) begin
			armed <= 1'b0; // R07
		end else if (!any_active) begin
			armed <= 1'b1; // R12
		end else if (any_edge) begin
			armed <= 1'b0; // R12
		end
	end

	// ========================================
	// Stop3 wake: raw enabled pin at its active level, registered into o_wake on i_sys_clk
	// Level based, since no clock is available to find an edge
	logic [NUM_PINS-1:0] raw_active;
	logic stop3_hit;
	// Same polarity match as the clocked path, on the raw pins
	assign raw_active = ~(i_key_input_pin_n ^ o_pin_polarity_select_n)
		& o_pin_irq_enable_n;
	assign stop3_hit = stop3 && |raw_active; // R06

	// ========================================
	// Event flag; set beats acknowledge in the same cycle
	logic set_flag;
	logic level_hold;
	assign set_flag = !deep_stop && (any_edge
		|| (o_edge_level_mode && any_active)); // R03 R05 R09
	assign level_hold = o_edge_level_mode && any_active; // R14

	// ========================================
	// Next flag and request enable, decided once for both users
	// The request flop uses these so it rises and falls with the
	// flag and follows a fresh enable write at the same edge
	logic next_flag;
	logic next_irq_en;
	always_comb begin
		if (deep_stop) begin
			next_flag = `KPI_RST_FLAG; // R07 R08
		end else if (set_flag) begin
			next_flag = 1'b1; // R13
		end else if (i_flag_acknowledge && !level_hold) begin
			next_flag = 1'b0; // R13 R14
		end else begin
			next_flag = o_event_flag;
		end
	end

	// Mirrors the enable bit of the control flop above
	always_comb begin
		if (deep_stop) begin
			next_irq_en = `KPI_RST_IRQ_EN;
		end else if (i_ctrl_write) begin
			next_irq_en = i_irq_request_enable;
		end else begin
			next_irq_en = o_irq_request_enable;
		end
	end

	// Flag register
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_event_flag <= `KPI_RST_FLAG;
		end else begin
			o_event_flag <= next_flag; // R13
		end
	end

	// ========================================
	// Request and wake outputs, registered
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_irq_request <= 1'b0;
			o_wake <= 1'b0;
		end else begin
			o_irq_request <= next_flag && next_irq_en; // R04 R16
			// Wait wakes on a new event, stop3 on the raw level
			o_wake <= o_irq_request_enable && !deep_stop
				&& (stop3_hit || set_flag); // R05 R06
		end
	end

	// Pull direction: on enabled pins polarity turns pull-up into pull-down
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pull_down_sel <= '0;
			o_pull_up_sel <= '0;
		end else begin
			o_pull_down_sel <= i_pull_enable & o_pin_irq_enable_n
				& o_pin_polarity_select_n; // R10
			o_pull_up_sel <= i_pull_enable & ~(o_pin_irq_enable_n
				& o_pin_polarity_select_n); // R10
		end
	end

	// ========================================
	// Checks
	a_req_follows_flag: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		o_irq_request |-> o_event_flag && o_irq_request_enable) // R16
		else $error("request without flag and enable");
	a_edge_sets_flag: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		any_edge && !deep_stop |=> o_event_flag) // R11 R13
		else $error("edge did not set flag");
	a_level_holds_flag: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		o_edge_level_mode && any_active && !deep_stop |=> o_event_flag) // R14
		else $error("flag cleared while level active");
	a_ack_clears: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		i_flag_acknowledge && !set_flag && !level_hold && !deep_stop
		|=> !o_event_flag) // R13
		else $error("acknowledge did not clear flag");
	a_deep_resets: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		deep_stop |=> !o_event_flag && o_pin_irq_enable_n == '0
		&& !o_irq_request_enable) // R07 R08
		else $error("deep stop left state");
	a_no_rearm_early: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		any_edge ##1 any_active |-> !armed) // R12
		else $error("rearmed while input active");
	a_disabled_quiet: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		o_pin_irq_enable_n == '0 && !o_event_flag |=> !o_event_flag) // R02
		else $error("disabled pin detected");
	a_pull_down_sel: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		o_pull_down_sel != '0 |-> $past(i_pull_enable) != '0) // R10
		else $error("pull-down without pull enable");
	a_stop3_wake: assert property (@(posedge i_sys_clk)
		disable iff (!i_arst_n)
		stop3_hit && o_irq_request_enable |=> o_wake) // R06
		else $error("stop3 event did not wake");
	c_edge_irq: cover property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) any_edge ##1 o_irq_request);
	c_level_hold: cover property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) i_flag_acknowledge && level_hold);
	c_stop3: cover property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) stop3_hit ##1 o_wake);
	c_deep_clear: cover property (@(posedge i_sys_clk)
		disable iff (!i_arst_n) o_event_flag && deep_stop ##1 !o_event_flag);

endmodule : keypad_irq_unit

// [key_switch_model.sv]
// Model of the external key switches that drive the four key pins
`timescale 1ns/10ps

module key_switch_model (
	input wire logic i_sys_clk,
	input wire logic [3:0] i_press_en,
	input wire logic [3:0] i_press_val,
	input wire logic [3:0] i_pull_up,
	input wire logic [3:0] i_pull_down,
	output logic [3:0] o_pin
);
	// ========================================
	// Pin levels
	logic [3:0] last; // Level seen on the previous cycle

	// Remember the last level so a floating pin never holds it
	always_ff @(posedge i_sys_clk) begin
		last <= o_pin;
	end

	// A released pin follows its pull; with no pull it wanders
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			o_pin[i] = i_press_en[i] ? i_press_val[i] :
				i_pull_up[i] ? 1'b1 : i_pull_down[i] ? 1'b0 : ~last[i];
		end
	end
endmodule : key_switch_model

// [tb_keypad_irq_unit.sv]
// Self-checking bench for the keypad wake interrupt unit
`timescale 1ns/10ps

module tb_keypad_irq_unit;
	// ========================================
	// Signals
	logic i_sys_clk = 1'b0;
	logic i_arst_n = 1'b0;
	logic [3:0] en = 4'h0, pol = 4'h0, pull = 4'hf, press = 4'hf, val = 4'hf;
	logic mode = 1'b0, ie = 1'b0, wr = 1'b0, ack = 1'b0;
	logic [3:0] pm = keypad_irq_pkg::PM_RUN;
	logic [3:0] pin, pd, pu, ren, rpol;
	logic flag, irq, rmode, rie, wake;
	int mismatches = 0, num_checks = 0, cycles = 0;
	int wakes = 0, w0 = 0; // Wake pulses seen, and a snapshot of them
	// Ordinary cases: enables, polarity, pin level, request enable, flag
	typedef struct packed {
		logic [3:0] en, pol, v;
		logic ie, ex;
	} row_s;
	row_s rows[5] = '{'{4'h1, 4'h0, 4'he, 1'b1, 1'b1},
		'{4'h1, 4'h1, 4'h1, 1'b1, 1'b1}, '{4'h0, 4'h0, 4'he, 1'b1, 1'b0},
		'{4'h8, 4'h8, 4'hf, 1'b0, 1'b1}, '{4'h2, 4'h0, 4'hd, 1'b1, 1'b1}};

	// ========================================
	// Clock, timeout and instances
	initial begin
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	// Whole run is a few hundred cycles; this ceiling catches a hang
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			test_done();
		end
	end
	// Count wake pulses so a one-cycle wake cannot slip between checks
	always @(posedge i_sys_clk) begin
		if (wake === 1'b1)
			wakes <= wakes + 1;
	end
	key_switch_model u_keys (.i_sys_clk(i_sys_clk), .i_press_en(press),
		.i_press_val(val), .i_pull_up(pu), .i_pull_down(pd), .o_pin(pin));
	keypad_irq_unit u_dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
		.i_key_input_pin_n(pin), .i_pin_irq_enable_n(en),
		.i_pin_polarity_select_n(pol), .i_edge_level_mode(mode),
		.i_irq_request_enable(ie), .i_flag_acknowledge(ack),
		.i_pull_enable(pull), .i_power_mode(pm), .i_ctrl_write(wr),
		.o_event_flag(flag), .o_irq_request(irq), .o_wake(wake),
		.o_pull_down_sel(pd), .o_pull_up_sel(pu), .o_pin_irq_enable_n(ren),
		.o_pin_polarity_select_n(rpol), .o_edge_level_mode(rmode),
		.o_irq_request_enable(rie));

	// ========================================
	// Tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Load all control fields with a one-cycle write pulse
	task automatic cfg(input logic [3:0] e, p, input logic m, r);
		@(posedge i_sys_clk);
		{en, pol, mode, ie, wr} <= {e, p, m, r, 1'b1};
		@(posedge i_sys_clk);
		wr <= 1'b0;
	endtask : cfg
	// Set pin levels, then allow sync plus flag latency to settle
	task automatic pins(input logic [3:0] v);
		@(posedge i_sys_clk);
		val <= v;
		repeat (5) @(posedge i_sys_clk);
	endtask : pins
	task automatic do_ack();
		@(posedge i_sys_clk);
		ack <= 1'b1;
		@(posedge i_sys_clk);
		ack <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
	endtask : do_ack
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// ========================================
	// Main sequence
	initial begin
		repeat (16) @(posedge i_sys_clk);
		i_arst_n <= 1'b1;
		foreach (rows[i]) begin
			cfg(rows[i].en, rows[i].pol, 1'b0, rows[i].ie);
			pins(~rows[i].pol);
			do_ack();
			chk(flag, 4'h0);
			pins(rows[i].v);
			chk(flag, rows[i].ex);
			chk(irq, rows[i].ex & rows[i].ie);
		end
		$display("test table done");
		// Second pin falls while the first is still held low
		cfg(4'h3, 4'h0, 1'b0, 1'b1);
		pins(4'hf);
		do_ack();
		pins(4'he);
		do_ack();
		chk(flag, 4'h0);
		pins(4'hc);
		chk(flag, 4'h0);
		$display("test lockout done");
		// Acknowledge refused while a level input is still active
		cfg(4'h1, 4'h0, 1'b1, 1'b1);
		pins(4'hf);
		do_ack();
		pins(4'he);
		do_ack();
		chk(flag, 4'h1);
		pins(4'hf);
		do_ack();
		chk(flag, 4'h0);
		$display("test level done");
		// Detection carries on in wait mode
		pm <= keypad_irq_pkg::PM_WAIT;
		cfg(4'h1, 4'h0, 1'b0, 1'b1);
		w0 = wakes;
		pins(4'he);
		chk(irq, 4'h1);
		chk(wakes != w0, 8'h1);
		pm <= keypad_irq_pkg::PM_RUN;
		$display("test wait done");
		// Stop3: the raw pin level alone raises wake
		cfg(4'h1, 4'h0, 1'b0, 1'b1);
		pins(4'hf);
		do_ack();
		pm <= keypad_irq_pkg::PM_STOP3;
		pins(4'he);
		chk(wake, 8'h1);
		chk(irq, 8'h1);
		$display("test stop3 done");
		// Reset in mid-run: every output but the mode bit is checked clear while it is held
		i_arst_n <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		chk({flag, irq, wake, rie}, 8'h0);
		chk({pd, pu}, 8'h0);
		chk({ren, rpol}, 8'h0);
		i_arst_n <= 1'b1;
		pm <= keypad_irq_pkg::PM_RUN;
		$display("test reset done");
		// Released pins settle on the pull chosen by polarity
		press <= 4'h0;
		cfg(4'hf, 4'h5, 1'b0, 1'b0);
		// Pull selects are registered one edge after the control load
		repeat (2) @(posedge i_sys_clk);
		chk(pd, 8'h5);
		chk(pu, 8'ha);
		chk(pin, 8'ha);
		// Pins without a pull enable get neither direction
		pull <= 4'h3;
		repeat (2) @(posedge i_sys_clk);
		chk(pd, 8'h1);
		chk(pu, 8'h2);
		press <= 4'hf;
		pull <= 4'hf;
		$display("test pull done");
		// Deep stop: no detection, and everything returns to reset
		cfg(4'h1, 4'h0, 1'b0, 1'b1);
		pins(4'hf);
		do_ack();
		pm <= keypad_irq_pkg::PM_DEEP;
		pins(4'he);
		chk(flag, 4'h0);
		pm <= keypad_irq_pkg::PM_RUN;
		pins(4'he);
		chk({ren, rpol}, 8'h0);
		chk({rmode, rie, flag, irq}, 8'h0);
		$display("test deep stop done");
		test_done();
	end
endmodule : tb_keypad_irq_unit
